//--- agpfe_top.sv
// graphics-port front end: strap capture, command decode, pci-66 limits
//
// Functional notes
// - power-good latches parity/add-detect pin into port select; 0 picks video output.
// - power-good latches live gen-3 detect into gen-3 strap bit.
// - gen-3 detect of 1 forces port select to 1.
// - gen-3 detect is reference comparator output: below 0.55 V means gen-3.
// - weak pull-up on parity pin enabled while detect shows non-gen-3.
// - parity/add-detect pin value is ignored when gen-3 detect is 1.
// - device never initiates enhanced cycles; target to main memory only.
// - enhanced and pci-semantic requests may interleave on the port.
// - gen-2 command decode: reads, writes, long reads, flush, fence.
// - gen-3 command decode: async read, async write, flush, fence.
// - high-priority requests skip address conflict checks.
// - pipe and sideband requests snoop global write buffer; frame ones do not.
// - 1X, 4X and pci-66 rates supported; 2X never.
// - pci-66 use bridges only hub-to-port memory writes.
// - pci-66 use supports no locked transactions.
// - pci-66 use has no system or parity error signalling.
// - pci-66 subsequent-data latency limit is 16 clocks, not 8.
// - captured straps stay fixed until next power cycle.
`timescale 1ns/1ps
`default_nettype none
module agpfe_top
    import agpfe_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_CLK_PORT,
    input wire logic I_RST_PORT,
    input wire logic I_POWER_GOOD,
    input wire logic I_PARITY_ADDCARD_SENSE_PIN,
    input wire logic I_REF_BELOW_THRESHOLD,
    input wire logic [1:0] I_RATE_REQ,
    input wire logic I_PCI66_MODE,
    input wire logic I_REQ_VALID,
    input wire agpfe_req_s I_REQ,
    input wire logic I_HUB_VALID,
    input wire logic I_HUB_IS_MEM_WR,
    input wire logic I_HUB_LOCK,
    input wire logic I_DATA_PHASE,
    output logic O_PARITY_PULLUP_EN,
    output logic O_PORT_SELECT_STRAP,
    output logic O_GEN3_DETECT_STRAP,
    output logic O_STRAPS_VALID,
    output logic O_DEC_VALID,
    output agpfe_dec_s O_DEC,
    output logic O_DEC_DROPPED,
    output logic O_INITIATE_ENH,
    output logic O_RATE_OK,
    output logic O_HUB_FWD,
    output logic O_LOCK_ACCEPT,
    output logic O_ERR_SIGNAL,
    output logic O_LATENCY_EXPIRED
);
    typedef enum logic [2:0] {
        ST_WAIT = 3'h1,
        ST_CAPT = 3'h2,
        ST_HELD = 3'h4
    } agpfe_st_e;

    // port-domain copies of the pins (two flops each)
    logic pg_s, par_s, det_s;
    agpfe_sync #(.W(3)) u_pin_sync (
        .i_clk(I_CLK_PORT),
        .i_rst(I_RST_PORT),
        .i_d({I_POWER_GOOD, I_PARITY_ADDCARD_SENSE_PIN, I_REF_BELOW_THRESHOLD}),
        .o_q({pg_s, par_s, det_s})
    );

    // gen-3 detect is the comparator output itself
    logic gen3_live;
    assign gen3_live = det_s;

    agpfe_st_e st_q;
    logic sel_q, g3_q;

    // capture sequencer: one-shot on power-good, reopened only by a port reset
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT) begin
            st_q <= ST_WAIT;
        end else begin
            case (st_q)
                ST_WAIT: if (pg_s) st_q <= ST_CAPT;
                ST_CAPT: st_q <= ST_HELD;
                ST_HELD: st_q <= ST_HELD;
                default: st_q <= ST_WAIT;
            endcase
        end
    end

    // strap latch; gen-3 forces graphics port personality
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT) begin
            sel_q <= 1'h0;
            g3_q <= 1'h0;
        end else if (st_q == ST_CAPT) begin
            sel_q <= par_s | gen3_live;
            g3_q <= gen3_live;
        end
    end

    // capture takes the pin, or forces select when gen-3 is seen
    chk_strap_force: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        (st_q == ST_CAPT) |=> (sel_q == ($past(par_s) | $past(gen3_live))))
        else $error("port select strap wrong");
    chk_gen3_capture: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        (st_q == ST_CAPT) |=> (g3_q == $past(gen3_live)))
        else $error("gen3 strap wrong");

    // pull-up follows the live detect, before and after capture
    logic pu_q;
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT) pu_q <= 1'h1;
        else pu_q <= ~gen3_live;
    end

    chk_pullup_follow: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        ##1 1'h1 |-> pu_q == ~$past(gen3_live))
        else $error("pullup not following detect");

    // gen-3 mode only meaningful with graphics port selected
    logic gen3_mode, held;
    assign held = (st_q == ST_HELD);
    assign gen3_mode = held & sel_q & g3_q;

    // straps are frozen once held; only a port reset reopens capture
    chk_gen3_select: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        held & g3_q |-> sel_q)
        else $error("gen3 without port select");
    chk_straps_hold: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        held |=> held && $stable(sel_q) && $stable(g3_q))
        else $error("strap changed after capture");

    // decode one command for the active generation
    function automatic agpfe_kind_e decode_cmd(input logic [3:0] c, input logic g3);
        agpfe_kind_e k;
        k = AGPFE_K_BAD;
        case (c)
            CMD_RD_LO: k = AGPFE_K_READ;
            CMD_WR_LO: k = AGPFE_K_WRITE;
            CMD_FLUSH: k = AGPFE_K_FLUSH;
            CMD_FENCE: k = AGPFE_K_FENCE;
            CMD_RD_HI, CMD_LRD_LO, CMD_LRD_HI: k = g3 ? AGPFE_K_BAD : AGPFE_K_READ;
            CMD_WR_HI: k = g3 ? AGPFE_K_BAD : AGPFE_K_WRITE;
            default: k = AGPFE_K_BAD;
        endcase
        return k;
    endfunction

    // frame requests are pci-semantic and may sit among enhanced ones
    agpfe_kind_e kind;
    logic take, drop;
    assign kind = decode_cmd(I_REQ.cmd, gen3_mode);
    assign take = I_REQ_VALID & held & sel_q & I_REQ.to_mem
                  & (kind != AGPFE_K_BAD);
    assign drop = I_REQ_VALID & ~take;

    chk_bad_dropped: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        I_REQ_VALID && gen3_mode && I_REQ.cmd == CMD_RD_HI |=> !O_DEC_VALID && O_DEC_DROPPED)
        else $error("reserved gen3 command accepted");

    // registered decoded request; high priority carries no conflict check
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT) begin
            O_DEC_VALID <= 1'b0;
            O_DEC <= '0;
            O_DEC_DROPPED <= 1'b0;
        end else begin
            O_DEC_VALID <= take;
            O_DEC_DROPPED <= drop;
            if (take) begin
                O_DEC.kind <= kind;
                O_DEC.hi_pri <= ~gen3_mode & ((I_REQ.cmd == CMD_RD_HI) |
                    (I_REQ.cmd == CMD_WR_HI) | (I_REQ.cmd == CMD_LRD_HI));
                O_DEC.long_rd <= ~gen3_mode & ((I_REQ.cmd == CMD_LRD_LO) |
                    (I_REQ.cmd == CMD_LRD_HI));
                O_DEC.snoop <= (I_REQ.src != SRC_FRAME);
                O_DEC.addr <= I_REQ.addr;
            end
        end
    end

    // frame requests never snoop; gen-2 high priority survives decode
    chk_frame_snoop: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        take && I_REQ.src == SRC_FRAME |=> O_DEC_VALID && !O_DEC.snoop)
        else $error("frame request marked snoop");
    chk_gen2_hipri: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        take && !gen3_mode && I_REQ.cmd == CMD_WR_HI
        |=> O_DEC.hi_pri && O_DEC.kind == AGPFE_K_WRITE)
        else $error("gen2 high-priority write misdecoded");

    // subsequent-data latency counter, limit set by pci-66 use
    logic [LAT_W-1:0] lat_q;
    logic [LAT_W-1:0] lat_lim;
    assign lat_lim = I_PCI66_MODE ? LAT_W'(LAT_PCI66_CLKS)
                                  : LAT_W'(LAT_NORMAL_CLKS);
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT | I_DATA_PHASE) lat_q <= '0;
        else if (lat_q != lat_lim) lat_q <= lat_q + LAT_W'(1);
    end
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT) O_LATENCY_EXPIRED <= 1'b0;
        else O_LATENCY_EXPIRED <= ~I_DATA_PHASE & (lat_q == lat_lim - LAT_W'(1));
    end

    // a pci-66 data phase followed by eight idle clocks
    sequence s_pci66_gap8;
        I_PCI66_MODE && I_DATA_PHASE ##1 (I_PCI66_MODE && !I_DATA_PHASE) [*8];
    endsequence
    chk_lat_pci66: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        s_pci66_gap8 |=> !O_LATENCY_EXPIRED)
        else $error("pci66 latency fired at 8");

    // rate check, hub bridging and the absent lock/error paths
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT) begin
            O_RATE_OK <= 1'h0;
            O_HUB_FWD <= 1'h0;
            O_LOCK_ACCEPT <= 1'h0;
            O_ERR_SIGNAL <= 1'h0;
            O_INITIATE_ENH <= 1'h0;
        end else begin
            O_RATE_OK <= (I_RATE_REQ != RATE_2X);
            O_HUB_FWD <= I_HUB_VALID & (~I_PCI66_MODE | I_HUB_IS_MEM_WR)
                         & ~I_HUB_LOCK;
            O_LOCK_ACCEPT <= 1'h0;
            O_ERR_SIGNAL <= 1'h0;
            O_INITIATE_ENH <= 1'h0;
        end
    end

    // refused rates, non-write hub traffic and the absent paths
    chk_no_2x: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        I_RATE_REQ == RATE_2X |=> !O_RATE_OK)
        else $error("2x rate accepted");
    chk_hub_memwr: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        I_PCI66_MODE && !I_HUB_IS_MEM_WR |=> !O_HUB_FWD)
        else $error("non-write bridged in pci66");
    chk_no_lock_err: assert property (@(posedge I_CLK_PORT) disable iff (I_RST_PORT)
        !O_LOCK_ACCEPT && !O_ERR_SIGNAL && !O_INITIATE_ENH)
        else $error("lock, error or initiation seen");

    // strap outputs
    always_ff @(posedge I_CLK_PORT) begin
        if (I_RST_PORT) begin
            O_PORT_SELECT_STRAP <= 1'h0;
            O_GEN3_DETECT_STRAP <= 1'h0;
            O_STRAPS_VALID <= 1'h0;
            O_PARITY_PULLUP_EN <= 1'h1;
        end else begin
            O_PORT_SELECT_STRAP <= sel_q;
            O_GEN3_DETECT_STRAP <= g3_q;
            O_STRAPS_VALID <= held;
            O_PARITY_PULLUP_EN <= pu_q;
        end
    end

    // system-clock side sees only the settled valid flag, via two flops
    logic sv_sys;
    agpfe_sync #(.W(1)) u_valid_sync (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_d(O_STRAPS_VALID),
        .o_q(sv_sys)
    );

    // once settled the valid flag never drops short of a reset
    chk_sys_valid_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        sv_sys |=> sv_sys)
        else $error("strap valid dropped in system domain");
endmodule
`default_nettype wire

//--- agpfe_pkg.sv
// package: constants and types for the graphics-port front end
package agpfe_pkg;
    // command codes on the command/byte-enable lines
    localparam logic [3:0] CMD_RD_LO = 4'h0;
    localparam logic [3:0] CMD_RD_HI = 4'h1;
    localparam logic [3:0] CMD_WR_LO = 4'h4;
    localparam logic [3:0] CMD_WR_HI = 4'h5;
    localparam logic [3:0] CMD_LRD_LO = 4'h8;
    localparam logic [3:0] CMD_LRD_HI = 4'h9;
    localparam logic [3:0] CMD_FLUSH = 4'hA;
    localparam logic [3:0] CMD_FENCE = 4'hC;
    // data-rate encodings
    localparam logic [1:0] RATE_1X = 2'h0;
    localparam logic [1:0] RATE_2X = 2'h1;
    localparam logic [1:0] RATE_4X = 2'h2;
    localparam logic [1:0] RATE_PCI66 = 2'h3;
    // latency limits in port clocks
    localparam int LAT_PCI66_CLKS = 16;
    localparam int LAT_NORMAL_CLKS = 8;
    localparam int LAT_W = 5;
    // request sources
    localparam logic [1:0] SRC_FRAME = 2'h0;
    localparam logic [1:0] SRC_PIPE = 2'h1;
    localparam logic [1:0] SRC_SBA = 2'h2;
    // decoded command classes
    typedef enum logic [3:0] {
        AGPFE_K_READ = 4'h0,
        AGPFE_K_WRITE = 4'h1,
        AGPFE_K_FLUSH = 4'h2,
        AGPFE_K_FENCE = 4'h3,
        AGPFE_K_BAD = 4'hF
    } agpfe_kind_e;
    // request as seen on the link
    typedef struct packed {
        logic [1:0] src;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic to_mem;
    } agpfe_req_s;
    // decoded request handed to the core
    typedef struct packed {
        agpfe_kind_e kind;
        logic hi_pri;
        logic long_rd;
        logic snoop;
        logic [31:0] addr;
    } agpfe_dec_s;
endpackage

//--- agpfe_sync.sv
// two-flop level synchroniser, width parameterised
`timescale 1ns/1ps
`default_nettype none
module agpfe_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- agpfe_card_model.sv
// behavioural add-in card: drives the sense pin and the reference level
`timescale 1ns/1ps
`default_nettype none
module agpfe_card_model (
    input wire logic [1:0] i_card,
    input wire logic i_pullup_en,
    output logic o_pin,
    output logic o_ref_below
);
    // card kind 0 video output, 1 gen-2, 2 gen-3
    // an undriven pin with the pull-up off reads low, never a stale 1
    always_comb begin
        case (i_card)
            2'h0: o_pin = 1'h0;
            2'h2: o_pin = 1'h0;
            default: o_pin = i_pullup_en;
        endcase
        o_ref_below = (i_card == 2'h2);
    end
endmodule
`default_nettype wire

//--- agpfe_top_tb.sv
// self-checking bench for the graphics-port front end
`timescale 1ns/1ps
`default_nettype none
module agpfe_top_tb import agpfe_pkg::*;;
    logic clk_sys = 1'h0;
    logic clk_port = 1'h0;
    logic rst = 1'h1;
    logic pg = 1'h0;
    logic [1:0] card = 2'h0;
    logic [1:0] rate = 2'h0;
    logic pci66 = 1'h0;
    logic rv = 1'h0;
    logic hv = 1'h0;
    logic hmw = 1'h0;
    logic hlk = 1'h0;
    logic dp = 1'h0;
    agpfe_req_s req = '0;
    logic ref_b, pin, pu, sel, g3, sv, dv, dd, ini, rok, hf, lka, err, lat;
    agpfe_dec_s dec;
    int failures = 0;
    int compares = 0;
    int cyc = 0;
    // the two clocks never share an edge with the drive point
    always #4 clk_sys = ~clk_sys;
    always #6 clk_port = ~clk_port;
    // the only device on the port; no second card ever shares it
    agpfe_card_model u_card (.i_card(card), .i_pullup_en(pu), .o_pin(pin),
        .o_ref_below(ref_b));
    agpfe_top u_dut (.I_CLK_SYS(clk_sys), .I_RST(rst), .I_CLK_PORT(clk_port),
        .I_RST_PORT(rst), .I_POWER_GOOD(pg), .I_PARITY_ADDCARD_SENSE_PIN(pin),
        .I_REF_BELOW_THRESHOLD(ref_b), .I_RATE_REQ(rate), .I_PCI66_MODE(pci66),
        .I_REQ_VALID(rv), .I_REQ(req), .I_HUB_VALID(hv), .I_HUB_IS_MEM_WR(hmw),
        .I_HUB_LOCK(hlk), .I_DATA_PHASE(dp), .O_PARITY_PULLUP_EN(pu),
        .O_PORT_SELECT_STRAP(sel), .O_GEN3_DETECT_STRAP(g3), .O_STRAPS_VALID(sv),
        .O_DEC_VALID(dv), .O_DEC(dec), .O_DEC_DROPPED(dd), .O_INITIATE_ENH(ini),
        .O_RATE_OK(rok), .O_HUB_FWD(hf), .O_LOCK_ACCEPT(lka), .O_ERR_SIGNAL(err),
        .O_LATENCY_EXPIRED(lat));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // inputs change 1 ns after the port clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_port);
        #1;
    endtask
    // leaves valid high so back-to-back requests need no gap
    task automatic send(input logic [1:0] src, input logic [3:0] c, input logic mem);
        req = '{src: src, cmd: c, addr: {28'h1234567, c}, to_mem: mem};
        rv = 1'h1;
        tick(1);
    endtask
    // {accepted, hi_pri, long_rd, kind}
    function automatic logic [6:0] exp_dec(input logic gen3, input logic [3:0] c);
        case (c)
            CMD_RD_LO: return {3'h4, AGPFE_K_READ};
            CMD_WR_LO: return {3'h4, AGPFE_K_WRITE};
            CMD_FLUSH: return {3'h4, AGPFE_K_FLUSH};
            CMD_FENCE: return {3'h4, AGPFE_K_FENCE};
            CMD_RD_HI: return gen3 ? 7'h00 : {3'h6, AGPFE_K_READ};
            CMD_WR_HI: return gen3 ? 7'h00 : {3'h6, AGPFE_K_WRITE};
            CMD_LRD_LO: return gen3 ? 7'h00 : {3'h5, AGPFE_K_READ};
            CMD_LRD_HI: return gen3 ? 7'h00 : {3'h7, AGPFE_K_READ};
            default: return 7'h00;
        endcase
    endfunction
    task automatic power_up(input logic [1:0] kind, input logic e_sel, input logic e_g3);
        int n;
        rst = 1'h1;
        pg = 1'h0;
        card = kind;
        tick(8);
        rst = 1'h0;
        tick(2);
        send(SRC_PIPE, CMD_RD_LO, 1'h1);
        rv = 1'h0;
        check("early_drop", dd, 1);
        pg = 1'h1;
        n = 0;
        while (sv !== 1'h1 && n < 20) begin
            tick(1);
            n++;
        end
        check("straps_valid", sv, 1);
        check("straps", {sel, g3}, {e_sel, e_g3});
        check("pullup", pu, !e_g3);
        pg = 1'h0;
        card = 2'h1;
        tick(6);
        check("straps_held", {sel, g3}, {e_sel, e_g3});
        card = kind;
        tick(2);
        $display("test power-up card %0d done", kind);
    endtask
    // every code; odd codes from alt source, even ones frame-based
    task automatic t_decode(input logic gen3, input logic [1:0] alt);
        logic [6:0] e;
        logic [31:0] last;
        for (int i = 0; i < 16; i++) begin
            e = exp_dec(gen3, 4'(i));
            send(i[0] ? alt : SRC_FRAME, 4'(i), 1'h1);
            check("dec_valid", dv, e[6]);
            check("dropped", dd, !e[6]);
            if (e[6]) begin
                check("kind", dec.kind, e[3:0]);
                check("hi_long", {dec.hi_pri, dec.long_rd}, e[5:4]);
                check("snoop", dec.snoop, i[0]);
                check("addr", dec.addr, req.addr);
                last = req.addr;
            end else begin
                check("kept_addr", dec.addr, last);
            end
        end
        rv = 1'h0;
        tick(1);
        $display("test decode gen3=%0d done", gen3);
    endtask
    task automatic t_pci66();
        int n;
        for (int r = 0; r < 4; r++) begin
            rate = 2'(r);
            tick(2);
            check("rate_ok", rok, 2'(r) != RATE_2X);
        end
        hv = 1'h1;
        for (int h = 0; h < 8; h++) begin
            {pci66, hmw, hlk} = 3'(h);
            tick(2);
            check("hub_fwd", hf, !hlk && (!pci66 || hmw));
            check("lock_err", {lka, err, ini}, 0);
        end
        hv = 1'h0;
        for (int m = 0; m < 2; m++) begin
            pci66 = m[0];
            dp = 1'h1;
            tick(1);
            dp = 1'h0;
            n = 0;
            while (lat !== 1'h1 && n < 40) begin
                tick(1);
                n++;
            end
            check("lat_clks", n, m ? LAT_PCI66_CLKS : LAT_NORMAL_CLKS);
            tick(4);
            check("lat_low", lat, 0);
        end
        $display("test pci66 limits done");
    endtask
    task automatic summarize();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the fewer than two hundred cycles the tests need
    always @(posedge clk_port) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        power_up(2'h0, 1'h0, 1'h0);
        send(SRC_PIPE, CMD_RD_LO, 1'h1);
        rv = 1'h0;
        check("video_drop", dd, 1);
        power_up(2'h1, 1'h1, 1'h0);
        t_decode(1'h0, SRC_PIPE);
        send(SRC_PIPE, CMD_RD_LO, 1'h0);
        rv = 1'h0;
        check("nonmem_drop", dd, 1);
        t_pci66();
        power_up(2'h2, 1'h1, 1'h1);
        t_decode(1'h1, SRC_SBA);
        summarize();
    end
endmodule
`default_nettype wire
